// ---- hw/ipc_controller.sv ----
// two-level interrupt priority controller with ten sources and fixed polling order
// assumes the core sequencer supplies one-cycle strobes for the flag sampling phase
// and machine cycle end, plus levels that describe the instruction in progress
//
// What this block does
// - each source owns one priority bit, 0 low level, 1 high level.
// - a high-level request may preempt a running low-level routine.
// - nothing vectors while a high-level routine runs.
// - high-level requests win over low-level ones polled together.
// - same-level ties follow fixed order Int0 first, Timer2 last.
// - global allow bit 7 low blocks all; high lets each enable decide.
// - main enable holds Timer2,UART1,Timer1,Int1,Timer0,Int0 at bits 5..0; bit 6 reserved.
// - auxiliary enable holds DDC bit 7, UART2 bit 4, I2C bit 1, USB bit 0.
// - main priority holds the same six sources at bits 5..0; 7,6 reserved.
// - auxiliary priority holds DDC 7, UART2 4, I2C 1, USB 0.
// - flags sampled at the sample phase, evaluated at the cycle-end strobe of that same machine cycle.
// - no call while an equal or higher level routine is in progress.
// - call only at the last machine cycle of an instruction.
// - no call during interrupt return or any enable/priority register access.
// - denied requests are forgotten; every poll uses fresh samples only.
// - acknowledge pushes PC without status word, then loads the vector.
// - vectors 0003h,000Bh,0013h,001Bh,0023h,002Bh,0033h,003Bh,0043h,004Bh per source.
// - interrupt return clears active level in-progress and pops two PC bytes.
// - plain subroutine return pops PC but keeps in-progress state.
// - both enable and both priority registers reset to zero.
`timescale 1ns/1ps
`default_nettype none

module ipc_controller
  import ipc_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic [7:0]               sfr_addr_in,
  input  wire logic                     sfr_wr_in,
  input  wire logic                     sfr_rd_in,
  input  wire logic [7:0]               sfr_wdata_in,
  output var  logic [7:0]               sfr_rdata_out,
  output var  logic                     sfr_hit_out,
  input  wire ipc_pkg::ipc_src_vec_type irq_flags_in,
  input  wire logic                     sample_phase_in,
  input  wire logic                     cycle_end_in,
  input  wire logic                     last_cycle_in,
  input  wire logic                     interrupt_exit_instr_instr_in,
  input  wire logic                     ret_instr_in,
  output var  logic                     hw_call_out,
  output var  ipc_pkg::ipc_call_type    call_out,
  output var  logic                     pc_pop_out,
  output var  logic                     in_prog_low_out,
  output var  logic                     in_prog_high_out
);
  import ipc_pkg::*;

  // registers
  logic [7:0]      int_enable_main;
  logic [7:0]      int_enable_aux;
  logic [7:0]      int_priority_main;
  logic [7:0]      int_priority_aux;
  ipc_src_vec_type sampled;
  logic            sample_valid;
  logic            reg_touched;
  logic            act_low;
  logic            act_high;

  // map main/aux register pair onto polling order
  function automatic ipc_src_vec_type to_poll_order(input logic [7:0] main_reg, input logic [7:0] aux_reg);
    ipc_src_vec_type v;
    v = '0;
    v[IPC_SRC_EXT0]   = main_reg[IPC_BIT_EXT0];
    v[IPC_SRC_UART2]  = aux_reg[IPC_BIT_UART2];
    v[IPC_SRC_TIMER0] = main_reg[IPC_BIT_TIMER0];
    v[IPC_SRC_I2C]    = aux_reg[IPC_BIT_I2C];
    v[IPC_SRC_EXT1]   = main_reg[IPC_BIT_EXT1];
    v[IPC_SRC_DDC]    = aux_reg[IPC_BIT_DDC];
    v[IPC_SRC_TIMER1] = main_reg[IPC_BIT_TIMER1];
    v[IPC_SRC_USB]    = aux_reg[IPC_BIT_USB];
    v[IPC_SRC_UART1]  = main_reg[IPC_BIT_UART1];
    v[IPC_SRC_TIMER2] = main_reg[IPC_BIT_TIMER2];
    return v;
  endfunction

  // lowest index wins: that is the one polled first
  function automatic logic [3:0] first_set(input ipc_src_vec_type v);
    logic [3:0] idx;
    idx = '0;
    for (int i = IPC_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] vector_of(input logic [3:0] src);
    logic [15:0] vec;
    case (src)
      IPC_SRC_EXT0:   vec = IPC_VEC_EXT0;
      IPC_SRC_UART2:  vec = IPC_VEC_UART2;
      IPC_SRC_TIMER0: vec = IPC_VEC_TIMER0;
      IPC_SRC_I2C:    vec = IPC_VEC_I2C;
      IPC_SRC_EXT1:   vec = IPC_VEC_EXT1;
      IPC_SRC_DDC:    vec = IPC_VEC_DDC;
      IPC_SRC_TIMER1: vec = IPC_VEC_TIMER1;
      IPC_SRC_USB:    vec = IPC_VEC_USB;
      IPC_SRC_UART1:  vec = IPC_VEC_UART1;
      IPC_SRC_TIMER2: vec = IPC_VEC_TIMER2;
      default:        vec = IPC_VEC_EXT0;
    endcase
    return vec;
  endfunction

  // register decode
  wire logic sel_en_main  = (sfr_addr_in == IPC_ADDR_EN_MAIN);
  wire logic sel_en_aux   = (sfr_addr_in == IPC_ADDR_EN_AUX);
  wire logic sel_pri_main = (sfr_addr_in == IPC_ADDR_PRI_MAIN);
  wire logic sel_pri_aux  = (sfr_addr_in == IPC_ADDR_PRI_AUX);
  wire logic sel_any      = sel_en_main | sel_en_aux | sel_pri_main | sel_pri_aux;
  wire logic access_now   = sel_any & (sfr_wr_in | sfr_rd_in);

  wire logic [7:0] read_mux = sel_en_main  ? int_enable_main :
                              sel_en_aux   ? int_enable_aux :
                              sel_pri_main ? int_priority_main :
                              sel_pri_aux  ? int_priority_aux : IPC_RESET_VALUE;

  // polling
  wire logic            global_allow = int_enable_main[IPC_BIT_GLOBAL];
  wire ipc_src_vec_type enable_vec   = to_poll_order(int_enable_main, int_enable_aux);
  wire ipc_src_vec_type prio_vec     = to_poll_order(int_priority_main, int_priority_aux);
  wire ipc_src_vec_type cand         = sample_valid ? (sampled & enable_vec & {IPC_NUM_SRC{global_allow}})
                                                    : '0;
  wire ipc_src_vec_type cand_high    = cand & prio_vec;
  wire ipc_src_vec_type cand_low     = cand & ~prio_vec;
  wire logic            win_high     = |cand_high;
  wire ipc_src_vec_type pick         = win_high ? cand_high : cand_low;
  wire logic [3:0]      win_src      = first_set(pick);

  // a running high routine blocks all, a running low routine blocks low only
  wire logic level_blocked = act_high | (act_low & ~win_high);
  wire logic instr_end     = cycle_end_in & last_cycle_in;
  wire logic instr_blocked = interrupt_exit_instr_instr_in | reg_touched | access_now;
  wire logic take_call     = instr_end & (|pick) & ~level_blocked & ~instr_blocked;
  wire logic interrupt_exit_instr_done     = instr_end & interrupt_exit_instr_instr_in;
  wire logic ret_done      = instr_end & ret_instr_in;

  wire logic next_act_high = take_call ? (act_high | win_high) : (interrupt_exit_instr_done ? 1'b0 : act_high);
  wire logic next_act_low  = take_call ? (act_low | ~win_high)
                                       : ((interrupt_exit_instr_done & ~act_high) ? 1'b0 : act_low);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_enable_main   <= IPC_RESET_VALUE;
      int_enable_aux    <= IPC_RESET_VALUE;
      int_priority_main <= IPC_RESET_VALUE;
      int_priority_aux  <= IPC_RESET_VALUE;
    end else if (sfr_wr_in) begin
      if (sel_en_main)  int_enable_main   <= sfr_wdata_in & IPC_MASK_EN_MAIN;
      if (sel_en_aux)   int_enable_aux    <= sfr_wdata_in & IPC_MASK_AUX;
      if (sel_pri_main) int_priority_main <= sfr_wdata_in & IPC_MASK_PRI_MAIN;
      if (sel_pri_aux)  int_priority_aux  <= sfr_wdata_in & IPC_MASK_AUX;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sfr_rdata_out <= IPC_RESET_VALUE;
      sfr_hit_out   <= 1'b0;
    end else begin
      sfr_rdata_out <= (sfr_rd_in & sel_any) ? read_mux : IPC_RESET_VALUE;
      sfr_hit_out   <= sfr_rd_in & sel_any;
    end
  end

  // each sample replaces the last; nothing pending is remembered
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sampled      <= '0;
      sample_valid <= 1'b0;
    end else if (sample_phase_in) begin
      sampled      <= irq_flags_in;
      sample_valid <= 1'b1;
    end
  end

  // register access anywhere in an instruction blocks the call at its end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_touched <= 1'b0;
    end else if (instr_end) begin
      reg_touched <= 1'b0;
    end else if (access_now) begin
      reg_touched <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_high <= 1'b0;
      act_low  <= 1'b0;
    end else begin
      act_high <= next_act_high;
      act_low  <= next_act_low;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hw_call_out      <= 1'b0;
      call_out         <= '0;
      pc_pop_out       <= 1'b0;
      in_prog_low_out  <= 1'b0;
      in_prog_high_out <= 1'b0;
    end else begin
      hw_call_out      <= take_call;
      pc_pop_out       <= interrupt_exit_instr_done | ret_done;
      in_prog_low_out  <= next_act_low;
      in_prog_high_out <= next_act_high;
      if (take_call) begin
        call_out.vector     <= vector_of(win_src);
        call_out.high_level <= win_high;
        call_out.source     <= win_src;
      end
    end
  end

  // polled candidates kept one cycle so the checks can see what the call chose from
  ipc_src_vec_type pick_q;
  wire ipc_src_vec_type below_win = pick_q & ((ipc_src_vec_type'(1) << call_out.source) - ipc_src_vec_type'(1));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pick_q <= '0;
    end else begin
      pick_q <= pick;
    end
  end

  // checks
  chk_high_blocks_all: assert property (@(posedge clk_in) disable iff (rst_in)
    act_high |=> !hw_call_out)
    else $error("call issued while high routine in progress");

  chk_low_preempt: assert property (@(posedge clk_in) disable iff (rst_in)
    ($past(act_low) && !$past(act_high) && hw_call_out) |-> call_out.high_level)
    else $error("low routine preempted by low request");

  chk_call_at_end: assert property (@(posedge clk_in) disable iff (rst_in)
    hw_call_out |-> $past(cycle_end_in) && $past(last_cycle_in))
    else $error("call outside last cycle of instruction");

  chk_no_call_interrupt_exit_instr: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(interrupt_exit_instr_instr_in) |-> !hw_call_out)
    else $error("call during interrupt return");

  chk_global_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    !int_enable_main[IPC_BIT_GLOBAL] |=> !hw_call_out)
    else $error("call with global allow clear");

  chk_vector_match: assert property (@(posedge clk_in) disable iff (rst_in)
    hw_call_out |-> call_out.vector == vector_of(call_out.source))
    else $error("vector does not match source");

  chk_high_first: assert property (@(posedge clk_in) disable iff (rst_in)
    take_call && |cand_high |=> call_out.high_level)
    else $error("low request served before high");

  chk_level_set: assert property (@(posedge clk_in) disable iff (rst_in)
    hw_call_out |-> (call_out.high_level ? in_prog_high_out : in_prog_low_out))
    else $error("in-progress flag not set on call");

  chk_interrupt_exit_instr_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    interrupt_exit_instr_done && act_high && !take_call |=> !act_high && act_low == $past(act_low))
    else $error("interrupt return cleared wrong level");

  chk_ret_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
    ret_done && !interrupt_exit_instr_instr_in && !take_call |=> act_low == $past(act_low) && act_high == $past(act_high))
    else $error("subroutine return changed in-progress state");

  chk_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    !int_enable_main[6] && !int_priority_main[7] && !int_priority_main[6])
    else $error("reserved bit set");

  chk_aux_unused: assert property (@(posedge clk_in) disable iff (rst_in)
    ((int_enable_aux & ~IPC_MASK_AUX) == 8'h00) && ((int_priority_aux & ~IPC_MASK_AUX) == 8'h00))
    else $error("unused auxiliary bit set");

  chk_poll_order: assert property (@(posedge clk_in) disable iff (rst_in)
    hw_call_out |-> (below_win == '0) && pick_q[call_out.source])
    else $error("call did not follow polling order");

  chk_prio_bit: assert property (@(posedge clk_in) disable iff (rst_in)
    hw_call_out |-> call_out.high_level == prio_vec[call_out.source])
    else $error("call level differs from source priority bit");

  chk_global_call: assert property (@(posedge clk_in) disable iff (rst_in)
    hw_call_out |-> $past(global_allow) && $past(enable_vec[call_out.source]))
    else $error("call from disabled source");

  chk_no_nest: assert property (@(posedge clk_in) disable iff (rst_in)
    ((act_low || act_high) && !win_high) |=> !hw_call_out)
    else $error("call while equal level routine in progress");

  chk_no_call_access: assert property (@(posedge clk_in) disable iff (rst_in)
    (access_now && instr_end) |=> !hw_call_out)
    else $error("call during register access");

  chk_fresh_sample: assert property (@(posedge clk_in) disable iff (rst_in)
    sample_phase_in |=> sampled == $past(irq_flags_in))
    else $error("flags not replaced at sample phase");

  chk_need_sample: assert property (@(posedge clk_in) disable iff (rst_in)
    !sample_valid |=> !hw_call_out)
    else $error("call before any flag sample");

  chk_call_held: assert property (@(posedge clk_in) disable iff (rst_in)
    !hw_call_out |-> $stable(call_out))
    else $error("call record changed without a call");

  chk_pop_interrupt_exit_instr: assert property (@(posedge clk_in) disable iff (rst_in)
    interrupt_exit_instr_done |=> pc_pop_out)
    else $error("no pop after interrupt return");

  chk_pop_ret: assert property (@(posedge clk_in) disable iff (rst_in)
    ret_done |=> pc_pop_out)
    else $error("no pop after subroutine return");

  chk_interrupt_exit_instr_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (interrupt_exit_instr_done && !act_high && act_low && !take_call) |=> !act_low)
    else $error("interrupt return left low level in progress");

  chk_hit_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (sfr_rd_in && sel_any) |=> sfr_hit_out)
    else $error("register read not answered");

  chk_rdata_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !$past(sfr_rd_in) |-> (sfr_rdata_out == IPC_RESET_VALUE) && !sfr_hit_out)
    else $error("read data shown without a read");

endmodule // ipc_controller

`default_nettype wire

// ---- hw/ipc_pkg.sv ----
// shared constants and types for the two-level interrupt priority controller
// assumes an 8-bit special function register bus driven by the core sequencer
package ipc_pkg;

  localparam int unsigned IPC_NUM_SRC = 10;

  // special function register addresses
  localparam logic [7:0] IPC_ADDR_EN_AUX   = 8'ha7;
  localparam logic [7:0] IPC_ADDR_EN_MAIN  = 8'ha8;
  localparam logic [7:0] IPC_ADDR_PRI_AUX  = 8'hb7;
  localparam logic [7:0] IPC_ADDR_PRI_MAIN = 8'hb8;

  // reset values and writable bits (reserved and unused bits read zero)
  localparam logic [7:0] IPC_RESET_VALUE     = 8'h00;
  localparam logic [7:0] IPC_MASK_EN_MAIN    = 8'hbf;
  localparam logic [7:0] IPC_MASK_PRI_MAIN   = 8'h3f;
  localparam logic [7:0] IPC_MASK_AUX        = 8'h93;

  // bit positions in the main enable / main priority registers
  localparam int unsigned IPC_BIT_GLOBAL = 7;
  localparam int unsigned IPC_BIT_TIMER2 = 5;
  localparam int unsigned IPC_BIT_UART1  = 4;
  localparam int unsigned IPC_BIT_TIMER1 = 3;
  localparam int unsigned IPC_BIT_EXT1   = 2;
  localparam int unsigned IPC_BIT_TIMER0 = 1;
  localparam int unsigned IPC_BIT_EXT0   = 0;
  // bit positions in the auxiliary enable / auxiliary priority registers
  localparam int unsigned IPC_BIT_DDC    = 7;
  localparam int unsigned IPC_BIT_UART2  = 4;
  localparam int unsigned IPC_BIT_I2C    = 1;
  localparam int unsigned IPC_BIT_USB    = 0;

  // source index = polling order, 0 polled first
  localparam logic [3:0] IPC_SRC_EXT0   = 4'h0;
  localparam logic [3:0] IPC_SRC_UART2  = 4'h1;
  localparam logic [3:0] IPC_SRC_TIMER0 = 4'h2;
  localparam logic [3:0] IPC_SRC_I2C    = 4'h3;
  localparam logic [3:0] IPC_SRC_EXT1   = 4'h4;
  localparam logic [3:0] IPC_SRC_DDC    = 4'h5;
  localparam logic [3:0] IPC_SRC_TIMER1 = 4'h6;
  localparam logic [3:0] IPC_SRC_USB    = 4'h7;
  localparam logic [3:0] IPC_SRC_UART1  = 4'h8;
  localparam logic [3:0] IPC_SRC_TIMER2 = 4'h9;

  // service routine entry points
  localparam logic [15:0] IPC_VEC_EXT0   = 16'h0003;
  localparam logic [15:0] IPC_VEC_TIMER0 = 16'h000b;
  localparam logic [15:0] IPC_VEC_EXT1   = 16'h0013;
  localparam logic [15:0] IPC_VEC_TIMER1 = 16'h001b;
  localparam logic [15:0] IPC_VEC_UART1  = 16'h0023;
  localparam logic [15:0] IPC_VEC_TIMER2 = 16'h002b;
  localparam logic [15:0] IPC_VEC_USB    = 16'h0033;
  localparam logic [15:0] IPC_VEC_DDC    = 16'h003b;
  localparam logic [15:0] IPC_VEC_I2C    = 16'h0043;
  localparam logic [15:0] IPC_VEC_UART2  = 16'h004b;

  typedef logic [IPC_NUM_SRC-1:0] ipc_src_vec_type;

  // what the core sequencer needs to perform the hardware long call
  typedef struct packed {
    logic [15:0] vector;
    logic        high_level;
    logic [3:0]  source;
  } ipc_call_type;

endpackage

// ---- tb/ipc_core_seq_model.sv ----
// core sequencer model: machine-cycle strobes for the interrupt controller
// assumes one clock domain; strobes move on the falling edge
`timescale 1ns/1ps
`default_nettype none

module ipc_core_seq_model #(
  parameter int unsigned MC_LEN = 4
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output var  logic sample_phase_out,
  output var  logic cycle_end_out
);
  int unsigned phase;
  int unsigned next_phase;

  assign next_phase = (phase == MC_LEN - 1) ? 0 : phase + 1;

  // short machine cycle keeps the run brief; order sample then end is what matters
  always @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase            <= 0;
      sample_phase_out <= 1'b0;
      cycle_end_out    <= 1'b0;
    end else begin
      phase            <= next_phase;
      sample_phase_out <= (next_phase == 1);
      cycle_end_out    <= (next_phase == MC_LEN - 1);
    end
  end
endmodule // ipc_core_seq_model

`default_nettype wire

// ---- tb/ipc_controller_tb.sv ----
// self-checking bench for the interrupt priority controller
// assumes the sequencer model supplies sample and cycle-end strobes
`timescale 1ns/1ps
`default_nettype none

module ipc_controller_tb;
  import ipc_pkg::*;

  localparam logic [15:0] VEC_TAB [10] = '{IPC_VEC_EXT0, IPC_VEC_UART2, IPC_VEC_TIMER0, IPC_VEC_I2C,
    IPC_VEC_EXT1, IPC_VEC_DDC, IPC_VEC_TIMER1, IPC_VEC_USB, IPC_VEC_UART1, IPC_VEC_TIMER2};
  localparam logic [7:0] ADDR_TAB [4] = '{IPC_ADDR_EN_AUX, IPC_ADDR_EN_MAIN, IPC_ADDR_PRI_AUX, IPC_ADDR_PRI_MAIN};
  localparam logic [7:0] MASK_TAB [4] = '{IPC_MASK_AUX, IPC_MASK_EN_MAIN, IPC_MASK_AUX, IPC_MASK_PRI_MAIN};

  logic            clk_in = 1'b0;
  logic            rst_in = 1'b1;
  logic [7:0]      addr = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [7:0]      wdata = 8'h00;
  logic [7:0]      rdata;
  logic            hit;
  ipc_src_vec_type flags = '0;
  logic            sample;
  logic            cyc_end;
  logic            last = 1'b1;
  logic            interrupt_exit_instr = 1'b0;
  logic            ret = 1'b0;
  logic            hw_call;
  ipc_call_type    call;
  logic            pc_pop;
  logic            ip_low;
  logic            ip_high;
  ipc_src_vec_type fm;
  int              error_cnt = 0;
  int              checks_done = 0;

  always #4 clk_in = ~clk_in;

  ipc_controller ipc_controller_inst (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .sfr_hit_out(hit), .irq_flags_in(flags),
    .sample_phase_in(sample), .cycle_end_in(cyc_end), .last_cycle_in(last), .interrupt_exit_instr_instr_in(interrupt_exit_instr),
    .ret_instr_in(ret), .hw_call_out(hw_call), .call_out(call), .pc_pop_out(pc_pop),
    .in_prog_low_out(ip_low), .in_prog_high_out(ip_high));

  ipc_core_seq_model ipc_core_seq_model_inst (.clk_in(clk_in), .rst_in(rst_in), .sample_phase_out(sample),
    .cycle_end_out(cyc_end));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk_in);
    wr    = 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    @(negedge clk_in);
    addr = a;
    rd   = 1'b1;
    @(negedge clk_in);
    rd   = 1'b0;
    chk({7'h00, hit, rdata}, {7'h00, exp_hit, exp});
  endtask

  task automatic wait_end();
    @(posedge clk_in);
    while (cyc_end !== 1'b1) @(posedge clk_in);
  endtask

  // mode: 0 plain, 1 interrupt return, 2 subroutine return, 3 not last cycle, 4 register access
  task automatic poll(input ipc_src_vec_type f, input logic [2:0] mode, input logic exp_call,
                      input logic [15:0] exp_vec);
    wait_end();
    @(negedge clk_in);
    flags = f;
    interrupt_exit_instr  = (mode == 3'h1);
    ret   = (mode == 3'h2);
    last  = (mode != 3'h3);
    if (mode == 3'h4) sfr_read(IPC_ADDR_PRI_AUX, 8'h00, 1'b1);
    wait_end();
    @(negedge clk_in);
    chk({15'h0000, hw_call}, {15'h0000, exp_call});
    chk({15'h0000, pc_pop}, {15'h0000, (mode == 3'h1) || (mode == 3'h2)});
    if (exp_call) chk(call.vector, exp_vec);
    flags = '0;
    interrupt_exit_instr  = 1'b0;
    ret   = 1'b0;
    last  = 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("checks made %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 4; i++) sfr_read(ADDR_TAB[i], IPC_RESET_VALUE, 1'b1);
    sfr_read(8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      sfr_write(ADDR_TAB[i], 8'hff);
      sfr_read(ADDR_TAB[i], MASK_TAB[i], 1'b1);
    end
    sfr_write(IPC_ADDR_PRI_MAIN, 8'h00);
    sfr_write(IPC_ADDR_PRI_AUX, 8'h00);
    poll('1, 3'h4, 1'b0, 16'h0000);
    poll('1, 3'h3, 1'b0, 16'h0000);
    poll('0, 3'h0, 1'b0, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      fm = '1;
      fm = fm << i;
      poll(fm, 3'h0, 1'b1, VEC_TAB[i]);
      chk({11'h000, call.high_level, call.source}, {11'h000, 1'b0, 4'(i)});
      chk({14'h0000, ip_high, ip_low}, 16'h0001);
      poll('1, 3'h1, 1'b0, 16'h0000);
      chk({14'h0000, ip_high, ip_low}, 16'h0000);
    end
    sfr_write(IPC_ADDR_EN_MAIN, 8'h3f);
    poll('1, 3'h0, 1'b0, 16'h0000);
    sfr_write(IPC_ADDR_EN_MAIN, 8'hbf);
    sfr_write(IPC_ADDR_PRI_MAIN, 8'h20);
    poll('1, 3'h0, 1'b1, IPC_VEC_TIMER2);
    chk({14'h0000, call.high_level, ip_high}, 16'h0003);
    poll('1, 3'h0, 1'b0, 16'h0000);
    poll('1, 3'h2, 1'b0, 16'h0000);
    chk({15'h0000, ip_high}, 16'h0001);
    poll('0, 3'h0, 1'b0, 16'h0000);
    poll('0, 3'h1, 1'b0, 16'h0000);
    chk({14'h0000, ip_high, ip_low}, 16'h0000);
    poll(10'h001, 3'h0, 1'b1, IPC_VEC_EXT0);
    poll(10'h001, 3'h0, 1'b0, 16'h0000);
    poll(10'h200, 3'h0, 1'b1, IPC_VEC_TIMER2);
    chk({14'h0000, ip_high, ip_low}, 16'h0003);
    poll('0, 3'h1, 1'b0, 16'h0000);
    chk({14'h0000, ip_high, ip_low}, 16'h0001);
    poll('0, 3'h1, 1'b0, 16'h0000);
    chk({14'h0000, ip_high, ip_low}, 16'h0000);
    tally_and_finish();
  end
endmodule // ipc_controller_tb

`default_nettype wire
